// >>> design/rxeqa_ctrl.sv
// Equalizer adaptation control top with APB configuration registers
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module rxeqa_ctrl (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic eq_mode_select_in,
    input wire logic eq_datapath_reset_in,
    input wire logic offset_loop_hold_in,
    input wire logic offset_loop_override_in,
    input wire logic linear_lowfreq_hold_in,
    input wire logic linear_lowfreq_override_in,
    input wire logic linear_highfreq_hold_in,
    input wire logic linear_highfreq_override_in,
    input wire logic gain_ctrl_hold_in,
    input wire logic gain_ctrl_override_in,
    input wire logic fb_lowfreq_hold_in,
    input wire logic fb_lowfreq_override_in,
    input wire logic threshold_loop_hold_in,
    input wire logic threshold_loop_override_in,
    input wire logic vpeak_loop_hold_in,
    input wire logic vpeak_loop_override_in,
    input wire logic [13:0] tap_n_hold_in,
    input wire logic [13:0] tap_n_override_in,
    input wire logic adapt_valid_in,
    input wire logic [20:0] adapt_up_in,
    output logic eq_path_linear_out,
    output logic [146:0] coef_bus_out
);
    ////////////////////////////////////////////////////////////////////////
    // Control input synchronisation

    wire [20:0] hold_raw = {tap_n_hold_in, vpeak_loop_hold_in,
        threshold_loop_hold_in, fb_lowfreq_hold_in, gain_ctrl_hold_in,
        linear_highfreq_hold_in, linear_lowfreq_hold_in,
        offset_loop_hold_in};
    wire [20:0] ovrd_raw = {tap_n_override_in, vpeak_loop_override_in,
        threshold_loop_override_in, fb_lowfreq_override_in,
        gain_ctrl_override_in, linear_highfreq_override_in,
        linear_lowfreq_override_in, offset_loop_override_in};
    logic [43:0] sync_q;

    rxeqa_sync #(.W(rxeqa_pkg::SYNC_W)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .d_in({eq_mode_select_in, eq_datapath_reset_in, hold_raw, ovrd_raw}),
        .q_out(sync_q)
    );

    wire mode_s = sync_q[43];
    wire rst_s = sync_q[42];
    wire [20:0] hold_s = sync_q[41:21];
    wire [20:0] ovrd_s = sync_q[20:0];

    ////////////////////////////////////////////////////////////////////////
    // APB slave

    rxeqa_pkg::rxeqa_cfg_t cfg [rxeqa_pkg::N_CFG];
    rxeqa_pkg::rxeqa_coef_t coef [rxeqa_pkg::N_LOOPS];

    wire access = psel_in & penable_in;
    wire wr_fire = access & pready_out & pwrite_in;
    wire next_pready = access & ~pready_out;
    wire aligned = (paddr_in[1:0] == 2'h0);
    wire cfg_hit = aligned && (paddr_in < rxeqa_pkg::CFG_END);
    wire status_hit = aligned && (paddr_in == rxeqa_pkg::STATUS_ADDR);
    wire coef_hit = aligned && (paddr_in >= rxeqa_pkg::COEF_BASE) &&
                    (paddr_in < rxeqa_pkg::COEF_END);
    wire [4:0] word_idx = paddr_in[6:2];
    wire any_hit = cfg_hit | status_hit | coef_hit;
    wire next_err = ~any_hit | (pwrite_in & ~cfg_hit);
    wire [31:0] status_word = {30'h0, rst_s, mode_s};
    wire [31:0] rd_data = cfg_hit ? {16'h0, cfg[word_idx]} :
                          status_hit ? status_word :
                          coef_hit ? {25'h0, coef[word_idx]} : 32'h0;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else if (ce_in) begin
            pready_out <= next_pready;
            pslverr_out <= next_pready & next_err;
            prdata_out <= (next_pready & ~pwrite_in) ? rd_data : 32'h0;
        end
    end

    // Configuration registers, two low byte lanes
    genvar c;
    generate
        for (c = 0; c < rxeqa_pkg::N_CFG; c++) begin : g_cfg
            wire sel = wr_fire & cfg_hit & (word_idx == 5'(c));
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    cfg[c] <= rxeqa_pkg::CFG_RESET;
                end else if (ce_in && sel) begin
                    if (pstrb_in[0]) begin
                        cfg[c][7:0] <= pwdata_in[7:0];
                    end
                    if (pstrb_in[1]) begin
                        cfg[c][15:8] <= pwdata_in[15:8];
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Mode routing

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            eq_path_linear_out <= 1'b0;
        end else if (ce_in) begin
            eq_path_linear_out <= mode_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Adaptation loops

    genvar i;
    generate
        for (i = 0; i < rxeqa_pkg::N_LOOPS; i++) begin : g_loop
            localparam int W = rxeqa_pkg::loop_width(i);
            localparam int LSB = rxeqa_pkg::cfg_lsb(i);
            localparam int CS = rxeqa_pkg::cfg_sel(i);
            localparam bit LIN = rxeqa_pkg::loop_linear(i);
            wire [W-1:0] ovrd_val = cfg[CS][LSB +: W];
            wire active = LIN ? mode_s : ~mode_s;
            logic [W-1:0] value;

            // Override, freeze and adapt per loop
            // Shared and per-tap fields
            rxeqa_loop #(.W(W)) u_loop (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .ce_in(ce_in),
                .dp_reset_in(rst_s),
                .hold_in(hold_s[i]),
                .override_in(ovrd_s[i]),
                .active_in(active),
                .step_valid_in(adapt_valid_in),
                .step_up_in(adapt_up_in[i]),
                .ovrd_val_in(ovrd_val),
                .coef_out(value)
            );
            assign coef[i] = rxeqa_pkg::rxeqa_coef_t'(value);
            assign coef_bus_out[i*rxeqa_pkg::COEF_W +: rxeqa_pkg::COEF_W] =
                coef[i];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_ovrd(int n);
        ce_in && ovrd_s[n] && !rst_s;
    endsequence

    sequence s_mode_steady;
        (ce_in && eq_mode_select_in) [*2];
    endsequence

    property p_route;
        ce_in |=> eq_path_linear_out == $past(mode_s);
    endproperty
    a_route: assert property (p_route) else $error("mode route wrong");

    property p_offset;
        s_ovrd(0) |=> coef[0] == $past(cfg[0][7:1]);
    endproperty
    a_offset: assert property (p_offset) else $error("offset override");

    property p_lin_lf;
        s_ovrd(1) |=> coef[1] == $past(cfg[1][15:9]);
    endproperty
    a_lin_lf: assert property (p_lin_lf) else $error("linear lf override");

    property p_lin_hf;
        s_ovrd(2) |=> coef[2] == $past(cfg[2][15:9]);
    endproperty
    a_lin_hf: assert property (p_lin_hf) else $error("linear hf override");

    property p_gain;
        s_ovrd(3) |=> coef[3] == {2'h0, $past(cfg[3][4:0])};
    endproperty
    a_gain: assert property (p_gain) else $error("gain override");

    property p_fb_lf;
        s_ovrd(4) |=> coef[4] == $past(cfg[1][15:9]);
    endproperty
    a_fb_lf: assert property (p_fb_lf) else $error("feedback lf override");

    property p_thresh;
        s_ovrd(5) |=> coef[5] == $past(cfg[4][15:9]);
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold override");

    property p_vpeak;
        s_ovrd(6) |=> coef[6] == $past(cfg[5][15:9]);
    endproperty
    a_vpeak: assert property (p_vpeak) else $error("vpeak override");

    property p_tap2;
        s_ovrd(7) |=> coef[7] == {1'b0, $past(cfg[6][14:9])};
    endproperty
    a_tap2: assert property (p_tap2) else $error("tap 2 override");

    property p_tap4;
        s_ovrd(9) |=> coef[9] == {2'h0, $past(cfg[8][13:9])};
    endproperty
    a_tap4: assert property (p_tap4) else $error("tap 4 override");

    property p_tap15;
        s_ovrd(20) |=> coef[20] == {2'h0, $past(cfg[19][13:9])};
    endproperty
    a_tap15: assert property (p_tap15) else $error("tap 15 override");

    property p_adapt;
        ce_in && !rst_s && !hold_s[7] && !ovrd_s[7] && !mode_s &&
        adapt_valid_in && adapt_up_in[7] && (coef[7] < 7'h3F)
        |=> coef[7] == $past(coef[7]) + 7'h01;
    endproperty
    a_adapt: assert property (p_adapt) else $error("tap 2 did not adapt");

    property p_sync;
        s_mode_steady |=> mode_s;
    endproperty
    a_sync: assert property (p_sync) else $error("mode sync latency");

    property p_freeze;
        hold_s[5] && !ovrd_s[5] && !rst_s |=> $stable(coef[5]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("frozen loop moved");

    property p_tap3;
        s_ovrd(8) |=> coef[8] == {1'b0, $past(cfg[7][14:9])};
    endproperty
    a_tap3: assert property (p_tap3) else $error("tap 3 override");

    property p_tap5;
        s_ovrd(10) |=> coef[10] == {2'h0, $past(cfg[9][13:9])};
    endproperty
    a_tap5: assert property (p_tap5) else $error("tap 5 override");

    property p_tap6;
        s_ovrd(11) |=> coef[11] == {2'h0, $past(cfg[10][13:9])};
    endproperty
    a_tap6: assert property (p_tap6) else $error("tap 6 override");

    property p_tap7;
        s_ovrd(12) |=> coef[12] == {2'h0, $past(cfg[11][13:9])};
    endproperty
    a_tap7: assert property (p_tap7) else $error("tap 7 override");

    property p_tap8;
        s_ovrd(13) |=> coef[13] == {2'h0, $past(cfg[12][13:9])};
    endproperty
    a_tap8: assert property (p_tap8) else $error("tap 8 override");

    property p_tap9;
        s_ovrd(14) |=> coef[14] == {2'h0, $past(cfg[13][13:9])};
    endproperty
    a_tap9: assert property (p_tap9) else $error("tap 9 override");

    property p_tap10;
        s_ovrd(15) |=> coef[15] == {2'h0, $past(cfg[14][13:9])};
    endproperty
    a_tap10: assert property (p_tap10) else $error("tap 10 override");

    property p_tap11;
        s_ovrd(16) |=> coef[16] == {2'h0, $past(cfg[15][13:9])};
    endproperty
    a_tap11: assert property (p_tap11) else $error("tap 11 override");

    property p_tap12;
        s_ovrd(17) |=> coef[17] == {2'h0, $past(cfg[16][13:9])};
    endproperty
    a_tap12: assert property (p_tap12) else $error("tap 12 override");

    property p_tap13;
        s_ovrd(18) |=> coef[18] == {2'h0, $past(cfg[17][13:9])};
    endproperty
    a_tap13: assert property (p_tap13) else $error("tap 13 override");

    property p_tap14;
        s_ovrd(19) |=> coef[19] == {2'h0, $past(cfg[18][13:9])};
    endproperty
    a_tap14: assert property (p_tap14) else $error("tap 14 override");

    property p_dp_reset;
        ce_in && rst_s |=> (coef[0] == 7'h00) && (coef[7] == 7'h00) &&
            (coef[20] == 7'h00);
    endproperty
    a_dp_reset: assert property (p_dp_reset) else $error("not cleared");

    property p_freeze_gain;
        hold_s[3] && !ovrd_s[3] && !rst_s |=> $stable(coef[3]);
    endproperty
    a_freeze_gain: assert property (p_freeze_gain) else $error("gain moved");

    property p_freeze_tap;
        hold_s[20] && !ovrd_s[20] && !rst_s |=> $stable(coef[20]);
    endproperty
    a_freeze_tap: assert property (p_freeze_tap) else $error("tap 15 moved");

    property p_lin_idle;
        !mode_s && !ovrd_s[1] && !rst_s |=> $stable(coef[1]);
    endproperty
    a_lin_idle: assert property (p_lin_idle) else $error("linear loop moved");

    property p_fb_idle;
        mode_s && !ovrd_s[7] && !rst_s |=> $stable(coef[7]);
    endproperty
    a_fb_idle: assert property (p_fb_idle) else $error("feedback tap moved");

    property p_adapt_down;
        ce_in && !rst_s && !hold_s[9] && !ovrd_s[9] && !mode_s &&
        adapt_valid_in && !adapt_up_in[9] && (coef[9] != 7'h00)
        |=> coef[9] == $past(coef[9]) - 7'h01;
    endproperty
    a_adapt_down: assert property (p_adapt_down) else $error("tap 4 stuck");
endmodule
`default_nettype wire

// >>> design/rxeqa_loop.sv
// One adaptation loop: adapt, freeze or override a coefficient
`timescale 1ns/1ps
`default_nettype none
module rxeqa_loop #(
    parameter int W = 7
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic dp_reset_in,
    input wire logic hold_in,
    input wire logic override_in,
    input wire logic active_in,
    input wire logic step_valid_in,
    input wire logic step_up_in,
    input wire logic [W-1:0] ovrd_val_in,
    output logic [W-1:0] coef_out
);
    logic [W-1:0] next_coef;
    wire at_max = &coef_out;
    wire at_min = ~|coef_out;
    wire [W-1:0] inc = W'(coef_out + 1'b1);
    wire [W-1:0] dec = W'(coef_out - 1'b1);
    wire [W-1:0] stepped = step_up_in ? (at_max ? coef_out : inc)
                                      : (at_min ? coef_out : dec);
    wire do_step = active_in & step_valid_in;

    // Priority: datapath reset, override, freeze, adapt
    assign next_coef = dp_reset_in ? rxeqa_pkg::COEF_INIT[W-1:0] :
                       override_in ? ovrd_val_in :
                       hold_in ? coef_out :
                       do_step ? stepped : coef_out;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            coef_out <= rxeqa_pkg::COEF_INIT[W-1:0];
        end else if (ce_in) begin
            coef_out <= next_coef;
        end
    end
endmodule
`default_nettype wire

// >>> design/rxeqa_sync.sv
// Two-stage synchroniser for asynchronous control levels
`timescale 1ns/1ps
`default_nettype none
module rxeqa_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            stage1 <= '0;
            q_out <= '0;
        end else if (ce_in) begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// >>> inc/rxeqa_pkg.sv
// Constants, types and loop tables for the equalizer adaptation control
package rxeqa_pkg;
    localparam int N_LOOPS = 21;
    localparam int N_CFG = 20;
    localparam int N_TAPS = 14;
    localparam int COEF_W = 7;
    localparam int CFG_W = 16;
    localparam int SYNC_W = 2 * N_LOOPS + 2;
    typedef logic [COEF_W-1:0] rxeqa_coef_t;
    typedef logic [CFG_W-1:0] rxeqa_cfg_t;

    // Loop indices
    localparam int L_OFFSET = 0;
    localparam int L_LIN_LF = 1;
    localparam int L_LIN_HF = 2;
    localparam int L_GAIN = 3;
    localparam int L_FB_LF = 4;
    localparam int L_THRESH = 5;
    localparam int L_VPEAK = 6;
    localparam int L_TAP2 = 7;
    localparam int L_TAP4 = 9;
    localparam int L_TAP15 = 20;

    // Configuration register indices
    localparam int C_OFFSET = 0;
    localparam int C_LOWFREQ = 1;
    localparam int C_HIGHFREQ = 2;
    localparam int C_GAIN = 3;
    localparam int C_THRESH = 4;
    localparam int C_VPEAK = 5;
    localparam int C_TAP2 = 6;
    localparam int C_TAP4 = 8;
    localparam int C_TAP15 = 19;

    // Override field positions
    localparam int OFFSET_LSB = 1;
    localparam int GAIN_LSB = 0;
    localparam int WIDE_LSB = 9;
    localparam int GAIN_W = 5;
    localparam int TAP_WIDE_W = 6;
    localparam int TAP_NARROW_W = 5;

    // Register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] CFG_BASE = 12'h000;
    localparam logic [11:0] CFG_END = 12'h050;
    localparam logic [11:0] STATUS_ADDR = 12'h080;
    localparam logic [11:0] COEF_BASE = 12'h100;
    localparam logic [11:0] COEF_END = 12'h154;
    localparam int STAT_LINEAR_BIT = 0;
    localparam int STAT_RESET_BIT = 1;

    // Reset values
    localparam rxeqa_coef_t COEF_INIT = 7'h00;
    localparam rxeqa_cfg_t CFG_RESET = 16'h0000;

    function automatic int loop_width(input int i);
        case (i)
            L_GAIN: return GAIN_W;
            L_TAP2, L_TAP2 + 1: return TAP_WIDE_W;
            default: return (i >= L_TAP4) ? TAP_NARROW_W : COEF_W;
        endcase
    endfunction

    function automatic int cfg_lsb(input int i);
        case (i)
            L_OFFSET: return OFFSET_LSB;
            L_GAIN: return GAIN_LSB;
            default: return WIDE_LSB;
        endcase
    endfunction

    function automatic int cfg_sel(input int i);
        case (i)
            L_FB_LF: return C_LOWFREQ;
            L_THRESH: return C_THRESH;
            L_VPEAK: return C_VPEAK;
            default: return (i >= L_TAP2) ? i - 1 : i;
        endcase
    endfunction

    function automatic bit loop_linear(input int i);
        return (i == L_LIN_LF) || (i == L_LIN_HF);
    endfunction
endpackage

// >>> test/rxeqa_user_model.sv
// Behavioural user logic driving the equalizer control inputs
`timescale 1ns/1ps
`default_nettype none
module rxeqa_user_model (
    input wire logic clk_in,
    output logic mode_out,
    output logic dp_reset_out,
    output logic [20:0] hold_out,
    output logic [20:0] ovrd_out,
    output logic valid_out,
    output logic [20:0] up_out
);
    initial begin
        mode_out = 1'h0;
        dp_reset_out = 1'h0;
        hold_out = 21'h0;
        ovrd_out = 21'h0;
        valid_out = 1'h0;
        up_out = 21'h0;
    end

    // Mode change always followed by a datapath reset pulse
    task automatic set_mode(input logic m);
        @(posedge clk_in);
        mode_out <= m;
        repeat (4) @(posedge clk_in);
        dp_reset_out <= 1'h1;
        repeat (4) @(posedge clk_in);
        dp_reset_out <= 1'h0;
        repeat (5) @(posedge clk_in);
    endtask

    task automatic set_loops(input logic [20:0] h, input logic [20:0] o);
        @(posedge clk_in);
        hold_out <= h;
        ovrd_out <= o;
        repeat (5) @(posedge clk_in);
    endtask

    task automatic steps(input int n, input logic [20:0] up);
        @(posedge clk_in);
        up_out <= up;
        valid_out <= 1'h1;
        repeat (n) @(posedge clk_in);
        valid_out <= 1'h0;
        repeat (3) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the equalizer adaptation control
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, mode, dpr, valid, linear, err;
    logic [20:0] hold, ovrd, up;
    logic [146:0] coef_bus;
    logic [15:0] cfg [20];
    logic [6:0] cur [21];
    logic lin = 1'h0;
    logic ce = 1'h1;
    logic [31:0] rd;
    int bad_count = 0;
    int comparisons = 0;

    always #50 clk_in = ~clk_in;

    rxeqa_user_model u_rxeqa_user_model (.clk_in(clk_in), .mode_out(mode),
        .dp_reset_out(dpr), .hold_out(hold), .ovrd_out(ovrd),
        .valid_out(valid), .up_out(up));

    rxeqa_ctrl u_rxeqa_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .ce_in(ce), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .eq_mode_select_in(mode),
        .eq_datapath_reset_in(dpr), .offset_loop_hold_in(hold[0]),
        .offset_loop_override_in(ovrd[0]),
        .linear_lowfreq_hold_in(hold[1]),
        .linear_lowfreq_override_in(ovrd[1]),
        .linear_highfreq_hold_in(hold[2]),
        .linear_highfreq_override_in(ovrd[2]),
        .gain_ctrl_hold_in(hold[3]), .gain_ctrl_override_in(ovrd[3]),
        .fb_lowfreq_hold_in(hold[4]), .fb_lowfreq_override_in(ovrd[4]),
        .threshold_loop_hold_in(hold[5]),
        .threshold_loop_override_in(ovrd[5]),
        .vpeak_loop_hold_in(hold[6]), .vpeak_loop_override_in(ovrd[6]),
        .tap_n_hold_in(hold[20:7]), .tap_n_override_in(ovrd[20:7]),
        .adapt_valid_in(valid), .adapt_up_in(up),
        .eq_path_linear_out(linear), .coef_bus_out(coef_bus));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_in);
        penable <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            test_done();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] ovr_val(input int i);
        case (i)
            0: return cfg[0][7:1];
            1, 4: return cfg[1][15:9];
            2: return cfg[2][15:9];
            3: return {2'h0, cfg[3][4:0]};
            5: return cfg[4][15:9];
            6: return cfg[5][15:9];
            7, 8: return {1'h0, cfg[i-1][14:9]};
            default: return {2'h0, cfg[i-1][13:9]};
        endcase
    endfunction

    // Saturating step count on a loop of its own width
    function automatic logic [6:0] stepped(input int i, input logic [6:0] v,
        input logic u, input int n);
        int mx;
        int r;
        mx = (i == 3 || i >= 9) ? 31 : (i == 7 || i == 8) ? 63 : 127;
        r = u ? int'(v) + n : int'(v) - n;
        r = (r > mx) ? mx : (r < 0) ? 0 : r;
        return r[6:0];
    endfunction

    task automatic check_loops(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            check({25'h0, coef_bus[i*7 +: 7]}, {25'h0, cur[i]});
        end
    endtask

    task automatic round(input logic [20:0] h, input logic [20:0] o,
        input int n);
        logic [20:0] u;
        u = 21'($urandom);
        u_rxeqa_user_model.set_loops(h, o);
        u_rxeqa_user_model.steps(n, u);
        for (int i = 0; i < 21; i++) begin
            if (o[i]) begin
                cur[i] = ovr_val(i);
            end else if (!h[i] && ((i == 1 || i == 2) == lin)) begin
                cur[i] = stepped(i, cur[i], u[i], n);
            end
        end
        check_loops(0, 6);
        check_loops(7, 20);
    endtask

    task automatic new_mode(input logic m);
        u_rxeqa_user_model.set_mode(m);
        lin = m;
        // Overridden loops reload their field once the reset drops
        foreach (cur[i]) cur[i] = ovrd[i] ? ovr_val(i) : 7'h00;
        check_loops(0, 20);
        check({31'h0, linear}, {31'h0, m});
        apb(1'h0, 12'h080, 32'h0, 4'hF, rd, err);
        check(rd, {31'h0, m});
        round(21'h0, 21'h0, 4);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 60000);
        bad_count++;
        test_done();
    end

    initial begin
        rd = $urandom(14048);
        repeat (2) @(posedge clk_in);
        rst_b_in <= 1'h1;
        @(posedge clk_in);
        foreach (cur[i]) cur[i] = 7'h00;
        check_loops(0, 20);
        apb(1'h0, 12'hFFC, 32'h0, 4'hF, rd, err);
        check({rd[30:0], err}, 32'h1);
        apb(1'h1, 12'h080, 32'h3, 4'hF, rd, err);
        check({31'h0, err}, 32'h1);
        for (int k = 0; k < 20; k++) begin
            cfg[k] = (k == 7) ? 16'h7E00 : 16'($urandom);
            apb(1'h1, 12'(4 * k), {16'hFFFF, cfg[k]}, 4'hF, rd, err);
        end
        apb(1'h1, 12'h014, 32'h0, 4'h1, rd, err);
        cfg[5][7:0] = 8'h00;
        apb(1'h0, 12'h014, 32'h0, 4'hF, rd, err);
        check(rd, {16'h0, cfg[5]});
        round(21'h1FFFFF, 21'h1FFFFF, 3);
        round(21'h1FFFFF, 21'h0, 5);
        round(21'h0, 21'h0, 6);
        // Steps offered while the enable is low must be ignored
        ce <= 1'h0;
        u_rxeqa_user_model.steps(6, 21'h1FFFFF);
        check_loops(0, 20);
        ce <= 1'h1;
        repeat (6) round(21'($urandom), 21'($urandom), int'($urandom % 9) + 1);
        for (int i = 0; i < 21; i++) begin
            apb(1'h0, 12'(256 + 4 * i), 32'h0, 4'hF, rd, err);
            check(rd, {25'h0, cur[i]});
        end
        new_mode(1'h1);
        repeat (3) round(21'($urandom), 21'($urandom), 5);
        for (int k = 0; k < 20; k++) begin
            cfg[k] = 16'hFFFF;
            apb(1'h1, 12'(4 * k), 32'hFFFF, 4'h3, rd, err);
        end
        round(21'h0, 21'h1FFFFF, 2);
        round(21'h0, 21'h0, 3);
        new_mode(1'h0);
        round(21'h0, 21'h0, 5);
        test_done();
    end
endmodule
`default_nettype wire
